// ==== inc/dio_pkg.sv ====
/*
 * Shared constants and types for the 48-channel bidirectional I/O port:
 * register offsets, control field layout, reset values and filter timing.
 * Assumes a single 10 MHz clock domain and an APB slave decoding a
 * 32-byte window whose base is chosen by the surrounding bus fabric.
 */
package dio_pkg;

	// channel layout: two banks of three 8-bit ports, third port split in nibbles
	localparam int CH_NUM = 48;
	localparam int GROUP_NUM = 8;
	localparam int BANK_W = 24;
	localparam int SYNC_STAGES = 2;

	// clock
	localparam int CLK_HZ = 10_000_000;

	// apb window (32 bytes, eight words)
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_DATA_LO = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_DATA_HI = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_EDGE = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h14;

	// control register fields
	localparam int CTRL_DIR_LSB = 0;
	localparam int CTRL_FILT_LSB = 8;
	localparam int FILT_SEL_W = 4;
	localparam int CTRL_BANK_BIT = 12;
	localparam int CTRL_W = 13;

	// reset values: all groups input, filter off, rising edge, interrupts off
	localparam logic [GROUP_NUM-1:0] DIR_RESET = 8'h00;
	localparam logic [FILT_SEL_W-1:0] FILT_RESET = 4'h0;
	localparam logic [CH_NUM-1:0] EDGE_RESET = 48'hFFFF_FFFF_FFFF;
	localparam logic [CH_NUM-1:0] IRQ_EN_RESET = 48'h0000_0000_0000;
	localparam logic [CH_NUM-1:0] OUT_RESET = 48'h0000_0000_0000;

	// filter: samples taken every 2**sel clocks, FILT_AGREE equal samples to accept
	localparam int PRESCALE_W = 16;
	localparam int FILT_AGREE = 3;

	// pin drive toward the pads
	typedef struct packed {
		logic [CH_NUM-1:0] level;
		logic [CH_NUM-1:0] oe;
	} pin_drive_type;

	// one decoded apb access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} bus_access_type;

endpackage : dio_pkg

// ==== core/input_glitch_filter.sv ====
/*
 * Per-bit digital filter for the 48 input lines.
 * Assumes its input is already synchronised to pclk; a setting of zero
 * passes the lines straight through a single register.
 */
module input_glitch_filter
	import dio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [CH_NUM-1:0] raw,
	input wire logic [FILT_SEL_W-1:0] sel,
	output logic [CH_NUM-1:0] clean
);

	logic [PRESCALE_W-1:0] div_q;
	logic tick;
	logic [FILT_AGREE-2:0][CH_NUM-1:0] hist_q;
	logic [CH_NUM-1:0] all_one;
	logic [CH_NUM-1:0] all_zero;

	// last count of the sample period for a given setting
	function automatic logic [PRESCALE_W-1:0] period_last(input logic [FILT_SEL_W-1:0] s);
		logic [PRESCALE_W:0] p;
		p = (PRESCALE_W+1)'(1) << s;
		return PRESCALE_W'(p - (PRESCALE_W+1)'(1));
	endfunction : period_last

	assign tick = (div_q == period_last(sel));

	// sample-rate divider; one-cycle enable rather than a derived clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= '0;
		else if (tick || sel == FILT_RESET)
			div_q <= '0;
		else
			div_q <= div_q + PRESCALE_W'(1);
	end

	// sample history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hist_q <= '0;
		else if (tick)
			hist_q <= {hist_q[FILT_AGREE-3:0], raw};
	end

	always_comb
	begin
		all_one = raw;
		all_zero = ~raw;
		for (int i = 0; i < FILT_AGREE-1; i++)
		begin
			all_one = all_one & hist_q[i];
			all_zero = all_zero & ~hist_q[i];
		end
	end

	// a bit changes only when every sample agrees, so chatter shorter than the window is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clean <= '0;
		else if (sel == FILT_RESET)
			clean <= raw;
		else if (tick)
			clean <= (clean | all_one) & ~all_zero; // RULE5
	end

endmodule : input_glitch_filter

// ==== core/bidir_io_port.sv ====
/*
 * 48-channel bidirectional digital I/O port with per-bit edge interrupts
 * and a programmable input filter, reached over APB in a 32-byte window.
 * Assumes pad_in arrives asynchronously and that the fabric decodes the
 * window base; pad drive levels and enables go to external tristate pads.
 */
// The APB interface to the registers and the register addresses were left to the implementer.

// Functional notes
// RULE1: direction set per group: eight-line groups and four-line groups, 48 lines total.
// RULE2: each input bit has its own interrupt enable and selectable edge.
// RULE3: all 48 enabled interrupt sources merge onto one interrupt output.
// RULE4: with rising edge selected, a low-to-high input transition raises the event.
// RULE5: every input can pass a software-programmed noise and chatter filter.
// RULE6: positive logic everywhere: one is high, zero is low.
// RULE7: all registers fit one 32-byte window.
// RULE8: detected edges set sticky pending flags; interrupt high while enabled flag pending.
module bidir_io_port
	import dio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CH_NUM-1:0] pad_in,
	output pin_drive_type pad_drive,
	output logic irq
);

	logic [CH_NUM-1:0] sync1_q;
	logic [CH_NUM-1:0] sync2_q;
	logic [CH_NUM-1:0] filt_in;
	logic [CH_NUM-1:0] prev_q;
	logic [CH_NUM-1:0] out_q;
	logic [GROUP_NUM-1:0] dir_q;
	logic [FILT_SEL_W-1:0] filt_sel_q;
	logic bank_q;
	logic [CH_NUM-1:0] edge_q;
	logic [CH_NUM-1:0] irq_en_q;
	logic [CH_NUM-1:0] irq_en_d;
	logic [CH_NUM-1:0] stat_q;
	logic [CH_NUM-1:0] stat_d;
	logic [CH_NUM-1:0] oe;
	logic [CH_NUM-1:0] event_hit;
	logic [CH_NUM-1:0] stat_clr;
	logic [CH_NUM-1:0] port_view;
	logic [31:0] prdata_q;
	bus_access_type acc;

	// expand the eight group direction bits to one enable per line
	function automatic logic [CH_NUM-1:0] expand_dir(input logic [GROUP_NUM-1:0] d);
		logic [CH_NUM-1:0] r;
		r = '0;
		for (int b = 0; b < 2; b++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				r[b*BANK_W + i] = d[b*4 + 0];
				r[b*BANK_W + 8 + i] = d[b*4 + 1];
			end
			for (int i = 0; i < 4; i++)
			begin
				r[b*BANK_W + 16 + i] = d[b*4 + 2];
				r[b*BANK_W + 20 + i] = d[b*4 + 3];
			end
		end
		return r;
	endfunction : expand_dir

	// the banked per-bit registers: 32 low channels or the 16 high ones
	function automatic logic [31:0] bank_read(input logic [CH_NUM-1:0] v, input logic hi);
		return hi ? {16'h0000, v[CH_NUM-1:32]} : v[31:0];
	endfunction : bank_read

	function automatic logic [CH_NUM-1:0] bank_write(input logic [CH_NUM-1:0] old,
		input logic [31:0] w, input logic hi);
		return hi ? {w[15:0], old[31:0]} : {old[CH_NUM-1:32], w};
	endfunction : bank_write

	// apb: zero wait states, no error response; the two spare words have no register and read zero
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_q;
	assign acc.wr = psel && penable && pwrite;
	assign acc.rd = psel && !penable && !pwrite;
	assign acc.addr = paddr; // RULE7
	assign acc.wdata = pwdata;

	// two-stage synchroniser on the pads
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= pad_in;
			sync2_q <= sync1_q;
		end
	end

	input_glitch_filter u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.raw(sync2_q),
		.sel(filt_sel_q),
		.clean(filt_in)
	);

	// pad drive: level straight from the latch, no inversion
	assign oe = expand_dir(dir_q); // RULE1
	assign pad_drive.level = out_q; // RULE6
	assign pad_drive.oe = oe;

	// output lines read back their latch, input lines their filtered level
	assign port_view = (out_q & oe) | (filt_in & ~oe); // RULE6

	// output latch, written in place of the data words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_q <= OUT_RESET;
		else if (acc.wr && acc.addr == OFS_DATA_LO)
			out_q <= {out_q[CH_NUM-1:32], acc.wdata};
		else if (acc.wr && acc.addr == OFS_DATA_HI)
			out_q <= {acc.wdata[15:0], out_q[31:0]};
	end

	// control: group directions, filter setting, bank select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir_q <= DIR_RESET;
			filt_sel_q <= FILT_RESET;
			bank_q <= 1'b0;
		end
		else if (acc.wr && acc.addr == OFS_CTRL)
		begin
			dir_q <= acc.wdata[CTRL_DIR_LSB +: GROUP_NUM]; // RULE1
			filt_sel_q <= acc.wdata[CTRL_FILT_LSB +: FILT_SEL_W]; // RULE5
			bank_q <= acc.wdata[CTRL_BANK_BIT];
		end
	end

	// per-bit edge choice: 1 rising, 0 falling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			edge_q <= EDGE_RESET;
		else if (acc.wr && acc.addr == OFS_EDGE)
			edge_q <= bank_write(edge_q, acc.wdata, bank_q); // RULE2
	end

	// per-bit interrupt enable; next value also feeds irq so a mask write acts at once
	always_comb
	begin
		irq_en_d = irq_en_q;
		if (acc.wr && acc.addr == OFS_IRQ_EN)
			irq_en_d = bank_write(irq_en_q, acc.wdata, bank_q); // RULE2
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_q <= IRQ_EN_RESET;
		else
			irq_en_q <= irq_en_d;
	end

	// previous filtered level for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_q <= '0;
		else
			prev_q <= filt_in;
	end

	// edge events; lines driven as outputs raise nothing
	always_comb
	begin
		event_hit = ((filt_in & ~prev_q & edge_q) // RULE4
			| (~filt_in & prev_q & ~edge_q)) & ~oe; // RULE2
	end

	// write-one-to-clear on the status word of the selected bank
	always_comb
	begin
		stat_clr = '0;
		if (acc.wr && acc.addr == OFS_IRQ_STAT)
			stat_clr = bank_write('0, acc.wdata, bank_q);
	end

	// sticky pending flags; a new event in the clear cycle survives
	always_comb
	begin
		stat_d = (stat_q & ~stat_clr) | event_hit; // RULE8
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_q <= '0;
		else
			stat_q <= stat_d;
	end

	// one level interrupt for all 48 sources, held while an enabled flag stays pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(stat_d & irq_en_d); // RULE3 RULE8
	end

	// read data captured in the setup cycle so it leaves a flop in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (acc.rd)
		begin
			if (acc.addr == OFS_DATA_LO)
				prdata_q <= port_view[31:0];
			else if (acc.addr == OFS_DATA_HI)
				prdata_q <= {16'h0000, port_view[CH_NUM-1:32]};
			else if (acc.addr == OFS_CTRL)
				prdata_q <= 32'({bank_q, filt_sel_q, dir_q});
			else if (acc.addr == OFS_EDGE)
				prdata_q <= bank_read(edge_q, bank_q);
			else if (acc.addr == OFS_IRQ_EN)
				prdata_q <= bank_read(irq_en_q, bank_q);
			else if (acc.addr == OFS_IRQ_STAT)
				prdata_q <= bank_read(stat_q, bank_q);
			else
				prdata_q <= 32'h0000_0000; // spare words read zero
		end
	end

endmodule : bidir_io_port

// ==== dv/bidir_io_port_properties.sv ====
/*
 * Port-level checks of the bidirectional I/O port, bound to bidir_io_port.
 * Assumes one pclk domain, zero-wait APB and the pin struct of dio_pkg.
 */
module bidir_io_port_properties
	import dio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [CH_NUM-1:0] pad_in,
	input wire pin_drive_type pad_drive,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr, rs, wr_ctl, wr_lo, wr_irq;
	logic [31:0] om, ol;
	// decoded bus phases; the irq registers sit at 0x10 and 0x14
	assign wr = psel && penable && pwrite;
	assign rs = psel && !penable && !pwrite;
	assign wr_ctl = wr && paddr[4:2] == 3'h2;
	assign wr_lo = wr && paddr[4:2] == 3'h0;
	assign wr_irq = wr && paddr[4:3] == 2'h2;
	assign om = pad_drive.oe[31:0];
	assign ol = pad_drive.level[31:0] & om;
	// group map: 8,8,4,4 lines per bank
	function automatic logic [47:0] grp(input logic [31:0] d);
		return {{4{d[7]}}, {4{d[6]}}, {8{d[5]}}, {8{d[4]}}, {4{d[3]}}, {4{d[2]}}, {8{d[1]}}, {8{d[0]}}};
	endfunction : grp
	a_ready_const: assert property (pready && !pslverr) else $error("slave stalled or flagged");
	a_ctrl_groups: assert property (wr_ctl |=> pad_drive.oe == grp($past(pwdata)))
		else $error("group enables wrong");
	a_oe_cause: assert property (!$stable(pad_drive.oe) |-> $past(wr_ctl)) else $error("enable moved alone");
	a_latch_lo: assert property (wr_lo |=> pad_drive.level[31:0] == $past(pwdata))
		else $error("latch not loaded");
	a_readback: assert property (rs && paddr[4:2] == 3'h0 |=> (prdata & $past(om)) == $past(ol))
		else $error("output readback wrong");
	a_hole_zero: assert property (rs && paddr[4:3] == 2'h3 |=> prdata == 32'h0) else $error("hole not zero");
	a_irq_sticky: assert property (irq && !(psel && pwrite) |=> irq) else $error("irq dropped alone");
	a_irq_fall: assert property ($fell(irq) |-> $past(wr_irq)) else $error("irq fell without write");
	c_irq_rise: cover property ($rose(irq));
	c_irq_fall: cover property ($fell(irq));
	c_ctrl_write: cover property (wr_ctl);
endmodule : bidir_io_port_properties

bind bidir_io_port bidir_io_port_properties bidir_io_port_properties_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_drive(pad_drive), .irq(irq));

// ==== dv/far_end_model.sv ====
/*
 * External logic-level equipment on the 48 lines.
 * Assumes the port's drive struct; lines it does not drive follow ext_val.
 */
module far_end_model
	import dio_pkg::*;
(
	input wire pin_drive_type pad_drive,
	input wire logic [CH_NUM-1:0] ext_val,
	output logic [CH_NUM-1:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// driven lines show the latch level, never a stale equipment value
	assign pad_in = (pad_drive.level & pad_drive.oe) | (ext_val & ~pad_drive.oe);
endmodule : far_end_model

// ==== dv/tb_top.sv ====
/*
 * Self-checking bench of bidir_io_port: APB master, random stimulus.
 * Assumes far_end_model on the pins and the bound property checker.
 */
module tb_top
	import dio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
	logic [4:0] paddr = 5'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [47:0] pad_in, rd, ext_val = 48'h0;
	pin_drive_type pad_drive;
	int mismatches = 0, total_checks = 0;
	bidir_io_port bidir_io_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pad_drive(pad_drive), .irq(irq));
	far_end_model far_end_model_i (.pad_drive(pad_drive), .ext_val(ext_val), .pad_in(pad_in));
	// 100 ns clock
	initial
		forever #50 pclk = ~pclk;
	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [47:0] g, input logic [47:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
			mismatches++;
		end
	endtask : chk
	// one apb transfer; ends at the negedge so outputs have settled
	task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1)
		begin
			mismatches++;
			tally_and_finish();
		end
		rd = {16'h0000, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask : xfer
	task wait_irq(input logic v);
		int n;
		for (n = 0; n < 40 && irq !== v; n++)
			@(negedge pclk);
		chk(irq, v);
	endtask : wait_irq
	function automatic logic [47:0] grp(input logic [7:0] d);
		return {{4{d[7]}}, {4{d[6]}}, {8{d[5]}}, {8{d[4]}}, {4{d[3]}}, {4{d[2]}}, {8{d[1]}}, {8{d[0]}}};
	endfunction : grp
	// main sequence
	initial
	begin
		int b, k;
		logic [7:0] dir;
		logic [31:0] v, m;
		logic [47:0] g;
		void'($urandom(32'hBD384885));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 48'h0);
		xfer(1'b0, OFS_EDGE, 32'h0);
		chk(rd, {16'h0000, EDGE_RESET[31:0]});
		xfer(1'b1, 5'h1C, 32'hFFFF_FFFF);
		xfer(1'b0, 5'h1C, 32'h0);
		chk(rd, 48'h0);
		$display("reset test done");
		dir = 8'($urandom);
		g = grp(dir);
		v = $urandom;
		xfer(1'b1, OFS_CTRL, {24'h000000, dir});
		chk(pad_drive.oe, g);
		xfer(1'b1, OFS_DATA_LO, v);
		xfer(1'b1, OFS_DATA_HI, v);
		chk(pad_drive.level, {v[15:0], v});
		xfer(1'b0, OFS_DATA_LO, 32'h0);
		chk(rd, {16'h0000, v & g[31:0]});
		$display("direction test done");
		// both banks: rising event, mask, sticky, clear, falling event
		for (b = 0; b < 2; b++)
		begin
			xfer(1'b1, OFS_CTRL, {19'h0, b[0], 12'h000});
			xfer(1'b1, OFS_IRQ_STAT, 32'hFFFF_FFFF);
			k = $urandom_range(b ? 15 : 31, 0);
			m = 32'h1 << k;
			xfer(1'b1, OFS_IRQ_EN, m);
			@(posedge pclk);
			ext_val[b * 32 + k] <= 1'b1;
			wait_irq(1'b1);
			xfer(1'b0, OFS_IRQ_STAT, 32'h0);
			chk(rd, {16'h0000, m});
			xfer(1'b1, OFS_IRQ_EN, 32'h0);
			chk(irq, 48'h0);
			xfer(1'b1, OFS_IRQ_EN, m);
			chk(irq, 48'h1);
			xfer(1'b1, OFS_IRQ_STAT, m);
			chk(irq, 48'h0);
			xfer(1'b1, OFS_EDGE, ~m);
			@(posedge pclk);
			ext_val[b * 32 + k] <= 1'b0;
			wait_irq(1'b1);
			xfer(1'b1, OFS_IRQ_STAT, m);
			$display("bank %0d interrupt test done", b);
		end
		// filter: a one-cycle glitch is rejected, a steady level passes
		xfer(1'b1, OFS_CTRL, 32'h0000_0100);
		xfer(1'b1, OFS_EDGE, 32'hFFFF_FFFF);
		k = $urandom_range(31, 0);
		xfer(1'b1, OFS_IRQ_EN, 32'h1 << k);
		@(posedge pclk);
		ext_val[k] <= 1'b1;
		@(posedge pclk);
		ext_val[k] <= 1'b0;
		repeat (30) @(negedge pclk);
		chk(irq, 48'h0);
		@(posedge pclk);
		ext_val[k] <= 1'b1;
		wait_irq(1'b1);
		$display("filter test done");
		tally_and_finish();
	end
endmodule : tb_top
